// >>> verilog/flash_erase_device.sv
// Flash end of the erase link: decodes frames, keeps the write enable latch,
// status and flag status, and times subsector, sector, die and bulk erases.
// Assumes the array reports stalls on erase_stall and exposes its sector locks.

module flash_erase_device #(
  parameter int unsigned SUBSECTOR_ERASE_CYCLES =
    flash_erase_pkg::SUBSECTOR_ERASE_TIME_US * 1000 / flash_erase_pkg::CLK_PERIOD_NS,
  parameter int unsigned SECTOR_ERASE_CYCLES =
    flash_erase_pkg::SECTOR_ERASE_TIME_US * 1000 / flash_erase_pkg::CLK_PERIOD_NS,
  parameter int unsigned DIE_ERASE_CYCLES =
    flash_erase_pkg::DIE_ERASE_TIME_US * 1000 / flash_erase_pkg::CLK_PERIOD_NS,
  parameter int unsigned BULK_ERASE_CYCLES =
    flash_erase_pkg::BULK_ERASE_TIME_US * 1000 / flash_erase_pkg::CLK_PERIOD_NS,
  parameter bit          BULK_SUPPORTED = 1'b1
) (
  // Clock and reset
  input  wire logic                                  aclk,
  input  wire logic                                  aresetn,
  // Link
  flash_link_if.device                               link,
  input  wire logic [1:0]                            link_mode,
  // Array side
  input  wire logic [flash_erase_pkg::SECTORS-1:0]   sector_lock,
  input  wire logic                                  erase_stall,
  output logic                                       erase_start,
  output logic                                       erase_done,
  output flash_erase_pkg::erase_kind_t               erase_kind,
  output logic [flash_erase_pkg::ADDR_BITS-1:0]      erase_base,
  output logic                                       erase_running
);

  typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_ERASE = 3'b010, ST_SUSP = 3'b100} dev_state_t;

  dev_state_t  st;
  logic        cs_s1, cs_s2, cs_s3;
  logic        ck_s1, ck_s2, ck_s3;
  logic [3:0]  dq_s1, dq_s2;
  logic [31:0] rx;
  logic [5:0]  cnt;
  logic        reading;
  logic        read_flags;
  logic [2:0]  out_idx;
  logic [7:0]  tx;
  logic        wel;
  logic        prot_err;
  logic        erase_err;
  logic        susp_flag;
  logic [31:0] progress;
  logic [31:0] elapsed;
  logic [31:0] dur_q;
  logic [31:0] limit_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {cs_s1, cs_s2, cs_s3} <= 3'h7;
      {ck_s1, ck_s2, ck_s3} <= 3'h0;
      dq_s1 <= 4'h0;
      dq_s2 <= 4'h0;
    end else begin
      {cs_s1, cs_s2, cs_s3} <= {link.cs_n, cs_s1, cs_s2};
      {ck_s1, ck_s2, ck_s3} <= {link.sclk, ck_s1, ck_s2};
      dq_s1 <= link.serial_data_in_line;
      dq_s2 <= dq_s1;
    end
  end

  wire       in_frame = !cs_s2;
  wire       ck_rise  = in_frame && ck_s2 && !ck_s3;
  wire       ck_fall  = in_frame && !ck_s2 && ck_s3;
  wire       cs_rise  = cs_s2 && !cs_s3;
  wire [1:0] sh       = flash_erase_pkg::lane_shift(link_mode);
  wire [5:0] cnt_next = cnt + (6'h01 << sh);
  wire [31:0] rx_next = (sh == 2'h2) ? {rx[27:0], dq_s2} :
                        (sh == 2'h1) ? {rx[29:0], dq_s2[1:0]} : {rx[30:0], dq_s2[0]};

  ////////////////////////////////////////////////////////////////////////////////
  // Frame capture and status read-out
  always_ff @(posedge aclk) begin
    if (!aresetn || !in_frame) begin
      rx         <= 32'h0000_0000;
      cnt        <= 6'h00;
      reading    <= 1'b0;
      read_flags <= 1'b0;
    end else if (ck_rise && cnt <= 6'd32) begin
      // Command and address bits taken on rising serial clock
      rx  <= rx_next;
      cnt <= cnt_next;
      if (cnt_next == 6'd8 && sh == 2'h0 && (rx_next[7:0] == flash_erase_pkg::CMD_READ_STATUS ||
          rx_next[7:0] == flash_erase_pkg::CMD_READ_FLAGS)) begin
        reading    <= 1'b1;
        read_flags <= rx_next[7:0] == flash_erase_pkg::CMD_READ_FLAGS;
      end
    end
  end

  wire running = st == ST_ERASE;
  wire idle    = st == ST_IDLE;
  wire [7:0] status_byte = {6'h00, wel, running};
  wire [7:0] flag_byte   = {!running, susp_flag, erase_err, 3'h0, prot_err, 1'b0};
  wire [7:0] out_byte    = read_flags ? flag_byte : status_byte;

  // Status stays readable during an erase
  always_ff @(posedge aclk) begin
    if (!aresetn || !in_frame) begin
      out_idx              <= 3'h0;
      tx                   <= 8'h00;
      link.status_out_line <= 1'b0;
    end else if (ck_fall && reading) begin
      out_idx <= out_idx + 3'h1;
      if (out_idx == 3'h0) begin
        link.status_out_line <= out_byte[7];
        tx                   <= {out_byte[6:0], 1'b0};
      end else begin
        link.status_out_line <= tx[7];
        tx                   <= {tx[6:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Command decode at the end of a frame
  // Only whole frames of exact length count
  // The counter holds bits, whatever the lane count
  wire       short_f  = cnt == 6'd8;
  wire       long_f   = cnt == 6'd32;
  wire [7:0] op       = long_f ? rx[31:24] : rx[7:0];
  wire [23:0] addr    = rx[23:0];
  wire is_sub  = long_f && op == flash_erase_pkg::CMD_SUBSECTOR_ERASE;
  wire is_sec  = long_f && op == flash_erase_pkg::CMD_SECTOR_ERASE;
  wire is_die  = long_f && op == flash_erase_pkg::CMD_DIE_ERASE;
  wire is_bulk = short_f && op == flash_erase_pkg::CMD_BULK_ERASE && BULK_SUPPORTED;

  flash_erase_pkg::erase_kind_t req_kind;
  assign req_kind = is_sub ? flash_erase_pkg::KIND_SUBSECTOR : is_sec ? flash_erase_pkg::KIND_SECTOR :
                    is_die ? flash_erase_pkg::KIND_DIE : flash_erase_pkg::KIND_BULK;

  // Erases are ignored while busy or suspended
  wire erase_req  = cs_rise && idle && (is_sub || is_sec || is_die || is_bulk);
  // Whole die or device is refused on any lock
  wire req_locked = (is_die || is_bulk) ? |sector_lock
                    : sector_lock[addr[flash_erase_pkg::ADDR_BITS-1:flash_erase_pkg::SECTOR_LOW_BITS]];
  wire erase_go     = erase_req && wel && !req_locked;
  wire erase_refuse = erase_req && wel && req_locked;
  wire cmd_short    = cs_rise && short_f && !running;
  wire do_wren      = cmd_short && op == flash_erase_pkg::CMD_WRITE_ENABLE;
  wire do_wrdi      = cmd_short && op == flash_erase_pkg::CMD_WRITE_DISABLE && !prot_err;
  wire do_clear     = cmd_short && op == flash_erase_pkg::CMD_CLEAR_FLAGS;
  wire do_suspend   = cs_rise && short_f && running && op == flash_erase_pkg::CMD_SUSPEND &&
                      (erase_kind == flash_erase_pkg::KIND_SUBSECTOR || erase_kind == flash_erase_pkg::KIND_SECTOR);
  wire do_resume    = cs_rise && short_f && st == ST_SUSP && op == flash_erase_pkg::CMD_RESUME;

  // Low address bits dropped to give the region base
  wire [23:0] base_sel =
    is_sub ? {addr[23:flash_erase_pkg::SUBSECTOR_LOW_BITS], 12'h000} :
    is_sec ? {addr[23:flash_erase_pkg::SECTOR_LOW_BITS], 16'h0000} : 24'h00_0000;
  wire [31:0] dur_sel =
    is_sub ? 32'(SUBSECTOR_ERASE_CYCLES) : is_sec ? 32'(SECTOR_ERASE_CYCLES) :
    is_die ? 32'(DIE_ERASE_CYCLES) : 32'(BULK_ERASE_CYCLES);
  wire done_ok = running && progress == dur_q;
  wire timeout = running && !done_ok && elapsed == limit_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Erase sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st         <= ST_IDLE;
      progress   <= 32'h0000_0000;
      elapsed    <= 32'h0000_0000;
      dur_q      <= 32'h0000_0001;
      limit_q    <= 32'h0000_0002;
      susp_flag  <= 1'b0;
      erase_kind <= flash_erase_pkg::KIND_SUBSECTOR;
      erase_base <= 24'h00_0000;
    end else begin
      case (st)
        ST_IDLE: begin
          if (erase_go) begin
            // Timed erase starts at select rising
            st         <= ST_ERASE;
            progress   <= 32'h0000_0000;
            elapsed    <= 32'h0000_0000;
            dur_q      <= dur_sel;
            limit_q    <= 32'(dur_sel * flash_erase_pkg::ERASE_LIMIT_FACTOR);
            erase_kind <= req_kind;
            erase_base <= base_sel;
          end
        end
        ST_ERASE: begin
          elapsed <= elapsed + 32'h0000_0001;
          if (!erase_stall) begin
            progress <= progress + 32'h0000_0001;
          end
          if (done_ok || timeout) begin
            st <= ST_IDLE;
          end else if (do_suspend) begin
            st        <= ST_SUSP;
            susp_flag <= 1'b1;
          end
        end
        ST_SUSP: begin
          if (do_resume) begin
            st        <= ST_ERASE;
            susp_flag <= 1'b0;
          end
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Write enable latch and error flags; for the latch a clear wins over a set, for the flags a set wins over a clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wel       <= 1'b0;
      prot_err  <= 1'b0;
      erase_err <= 1'b0;
    end else begin
      if (erase_go || do_clear || do_wrdi || timeout) begin
        wel <= 1'b0;
      end else if (do_wren) begin
        wel <= 1'b1;
      end
      if (erase_refuse) begin
        prot_err <= 1'b1;
      end else if (do_clear) begin
        prot_err <= 1'b0;
      end
      if (erase_refuse || timeout) begin
        erase_err <= 1'b1;
      end else if (do_clear) begin
        erase_err <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      erase_start   <= 1'b0;
      erase_done    <= 1'b0;
      erase_running <= 1'b0;
    end else begin
      erase_start   <= erase_go;
      erase_done    <= done_ok;
      erase_running <= running;
    end
  end

endmodule

// >>> verilog/flash_erase_pkg.sv
// Shared constants for the serial flash erase link: command codes, status bits,
// erase times and the register map of the controller end.
// Assumes both ends run on one 100 MHz clock, aclk.
package flash_erase_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Command codes
  localparam logic [7:0] CMD_WRITE_ENABLE    = 8'h06;
  localparam logic [7:0] CMD_WRITE_DISABLE   = 8'h04;
  localparam logic [7:0] CMD_READ_STATUS     = 8'h05;
  localparam logic [7:0] CMD_READ_FLAGS      = 8'h70;
  localparam logic [7:0] CMD_CLEAR_FLAGS     = 8'h50;
  localparam logic [7:0] CMD_SUBSECTOR_ERASE = 8'h20;
  localparam logic [7:0] CMD_SECTOR_ERASE    = 8'hd8;
  localparam logic [7:0] CMD_DIE_ERASE       = 8'hc4;
  localparam logic [7:0] CMD_BULK_ERASE      = 8'hc7;
  localparam logic [7:0] CMD_SUSPEND         = 8'h75;
  localparam logic [7:0] CMD_RESUME          = 8'h7a;

  ////////////////////////////////////////////////////////////////////////////////
  // Frame layout
  localparam int ADDR_BITS          = 24;
  localparam int SUBSECTOR_LOW_BITS = 12;
  localparam int SECTOR_LOW_BITS    = 16;
  localparam int SECTORS            = 1 << (ADDR_BITS - SECTOR_LOW_BITS);
  localparam logic [1:0] MODE_EXTENDED = 2'h0;
  localparam logic [1:0] MODE_DUAL     = 2'h1;
  localparam logic [1:0] MODE_QUAD     = 2'h2;

  typedef enum logic [1:0] {
    KIND_SUBSECTOR = 2'h0,
    KIND_SECTOR    = 2'h1,
    KIND_DIE       = 2'h2,
    KIND_BULK      = 2'h3
  } erase_kind_t;

  // Status and flag status bit positions
  localparam int STAT_WIP_BIT      = 0;
  localparam int STAT_WEL_BIT      = 1;
  localparam int FLAG_READY_BIT    = 7;
  localparam int FLAG_SUSPEND_BIT  = 6;
  localparam int FLAG_ERASE_ERR_BIT = 5;
  localparam int FLAG_PROT_ERR_BIT = 1;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS           = 10;
  localparam int SUBSECTOR_ERASE_TIME_US = 100;
  localparam int SECTOR_ERASE_TIME_US    = 700;
  localparam int DIE_ERASE_TIME_US       = 2000;
  localparam int BULK_ERASE_TIME_US      = 4000;
  localparam int ERASE_LIMIT_FACTOR      = 2;
  localparam int LINK_HALF_CYCLES        = 4;
  localparam int CS_GAP_CYCLES           = 8;

  ////////////////////////////////////////////////////////////////////////////////
  // Controller register map (AXI4-Lite byte offsets)
  localparam logic [7:0] REG_LINK_ADDR = 8'h00;
  localparam logic [7:0] REG_LINK_CMD  = 8'h04;
  localparam logic [7:0] REG_LINK_STAT = 8'h08;
  localparam int CMD_OP_LSB      = 0;
  localparam int CMD_MODE_LSB    = 8;
  localparam int CMD_ADDR_EN_BIT = 10;
  localparam int CMD_READ_EN_BIT = 11;
  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_RX_LSB     = 8;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Log2 of the lanes used per serial clock in a mode
  function automatic logic [1:0] lane_shift(input logic [1:0] mode);
    lane_shift = (mode == MODE_QUAD) ? 2'h2 : (mode == MODE_DUAL) ? 2'h1 : 2'h0;
  endfunction

endpackage

// >>> verilog/flash_link_if.sv
// Serial link between the flash controller and the flash erase logic.
// Data lines run controller to flash only; status returns on one line.
interface flash_link_if;
  logic       cs_n;
  logic       sclk;
  logic [3:0] serial_data_in_line;
  logic       status_out_line;

  modport host (output cs_n, output sclk, output serial_data_in_line, input status_out_line);
  modport device (input cs_n, input sclk, input serial_data_in_line, output status_out_line);
endinterface

// >>> verilog/flash_erase_host.sv
// Flash controller end: software writes address and command over AXI4-Lite,
// the block sends one frame per command write taken while idle and may read back one byte.
// Assumes the flash end samples on rising serial clock edges.
module flash_erase_host (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  input  wire logic [2:0]  arprot,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  // Link
  flash_link_if.host       link
);

  typedef enum logic [2:0] {H_IDLE = 3'b001, H_SHIFT = 3'b010, H_GAP = 3'b100} host_state_t;

  host_state_t st;
  logic [23:0] addr_q;
  logic [11:0] cmd_q;
  logic [7:0]  rx_byte;
  logic [31:0] tx;
  logic [2:0]  div;
  logic [5:0]  tx_left;
  logic [3:0]  rd_left;
  logic [3:0]  gap;
  logic        so_s1;
  logic        so_s2;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      old[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
    merge = old;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Register access
  wire        wr_take  = awvalid && wvalid && !bvalid;
  wire        hit_addr = awaddr == flash_erase_pkg::REG_LINK_ADDR;
  wire        hit_cmd  = awaddr == flash_erase_pkg::REG_LINK_CMD;
  wire        wr_ok    = hit_addr || hit_cmd;
  wire [31:0] cmd_new  = merge({20'h0_0000, cmd_q}, wdata, wstrb);
  wire        start    = wr_take && hit_cmd && st == H_IDLE;
  wire [1:0]  new_sh   = flash_erase_pkg::lane_shift(cmd_new[flash_erase_pkg::CMD_MODE_LSB +: 2]);
  wire        new_adr  = cmd_new[flash_erase_pkg::CMD_ADDR_EN_BIT];
  wire [5:0]  new_bits = new_adr ? 6'd32 : 6'd8;
  wire [1:0]  cur_sh   = flash_erase_pkg::lane_shift(cmd_q[flash_erase_pkg::CMD_MODE_LSB +: 2]);
  wire        rd_ok    = araddr == flash_erase_pkg::REG_LINK_ADDR || araddr == flash_erase_pkg::REG_LINK_CMD
                         || araddr == flash_erase_pkg::REG_LINK_STAT;
  wire [31:0] rd_mux   = (araddr == flash_erase_pkg::REG_LINK_ADDR) ? {8'h00, addr_q} :
                         (araddr == flash_erase_pkg::REG_LINK_CMD) ? {20'h0_0000, cmd_q} :
                         (araddr == flash_erase_pkg::REG_LINK_STAT) ? {16'h0000, rx_byte, 7'h00, st != H_IDLE} :
                         32'h0000_0000;

  assign awready = wr_take;
  assign wready  = wr_take;
  assign arready = !rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_q <= 24'h00_0000;
      cmd_q  <= 12'h000;
      bvalid <= 1'b0;
      bresp  <= flash_erase_pkg::RESP_OKAY;
    end else begin
      if (wr_take) begin
        bvalid <= 1'b1;
        bresp  <= wr_ok ? flash_erase_pkg::RESP_OKAY : flash_erase_pkg::RESP_SLVERR;
        if (hit_addr) begin
          addr_q <= 24'(merge({8'h00, addr_q}, wdata, wstrb));
        end
        if (start) begin
          cmd_q <= cmd_new[11:0];
        end
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= flash_erase_pkg::RESP_OKAY;
    end else if (arvalid && !rvalid) begin
      rvalid <= 1'b1;
      rdata  <= rd_mux;
      rresp  <= rd_ok ? flash_erase_pkg::RESP_OKAY : flash_erase_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Frame engine: serial clock is aclk divided by eight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      so_s1 <= 1'b0;
      so_s2 <= 1'b0;
    end else begin
      so_s1 <= link.status_out_line;
      so_s2 <= so_s1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st                       <= H_IDLE;
      link.cs_n                <= 1'b1;
      link.sclk                <= 1'b0;
      link.serial_data_in_line <= 4'h0;
      tx      <= 32'h0000_0000;
      div     <= 3'h0;
      tx_left <= 6'h00;
      rd_left <= 4'h0;
      gap     <= 4'h0;
      rx_byte <= 8'h00;
    end else begin
      case (st)
        H_IDLE: begin
          if (start) begin
            // Command first, then address, all on the chosen lanes
            tx        <= {cmd_new[7:0], new_adr ? addr_q : 24'h00_0000};
            tx_left   <= new_bits >> new_sh;
            rd_left   <= cmd_new[flash_erase_pkg::CMD_READ_EN_BIT] ? 4'd8 : 4'd0;
            div       <= 3'h0;
            link.cs_n <= 1'b0;
            st        <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          div <= div + 3'h1;
          if (div == 3'h0) begin
            if (tx_left != 6'h00) begin
              case (cur_sh)
                2'h2:    link.serial_data_in_line <= tx[31:28];
                2'h1:    link.serial_data_in_line <= {2'h0, tx[31:30]};
                default: link.serial_data_in_line <= {3'h0, tx[31]};
              endcase
              tx <= tx << (3'h1 << cur_sh);
            end else begin
              link.serial_data_in_line <= 4'h0;
            end
          end
          if (div == 3'(flash_erase_pkg::LINK_HALF_CYCLES)) begin
            link.sclk <= 1'b1;
          end
          if (div == 3'h7) begin
            link.sclk <= 1'b0;
            if (tx_left != 6'h00) begin
              tx_left <= tx_left - 6'h01;
            end else begin
              rx_byte <= {rx_byte[6:0], so_s2};
              rd_left <= rd_left - 4'h1;
            end
            // Chip select rises only after the last full byte
            if ((tx_left == 6'h01 && rd_left == 4'h0) || (tx_left == 6'h00 && rd_left == 4'h1)) begin
              link.cs_n <= 1'b1;
              gap       <= 4'h0;
              st        <= H_GAP;
            end
          end
        end
        H_GAP: begin
          gap <= gap + 4'h1;
          if (gap == 4'(flash_erase_pkg::CS_GAP_CYCLES - 1)) begin
            st <= H_IDLE;
          end
        end
        default: st <= H_IDLE;
      endcase
    end
  end

endmodule

// >>> verification/flash_erase_chk.sv
// Checker for the flash erase link wires: serial clock shape and select framing.
// Assumes the controller end drives the link from aclk; instantiated beside the link.
module flash_erase_chk (
  // Clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // Link
  input wire logic       cs_n,
  input wire logic       sclk,
  input wire logic [3:0] serial_data_in_line,
  input wire logic       status_out_line
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [7:0] nclk;
  // Serial clocks seen in the current frame
  always_ff @(posedge aclk) begin
    if (!aresetn || cs_n) nclk <= 8'h00;
    else if ($rose(sclk)) nclk <= nclk + 8'h01;
  end
  ////////////////////////////////////////
  property p_idle; cs_n |-> !sclk; endproperty
  a_idle: assert property (p_idle) else $error("clock high while deselected");
  property p_in_frame; $rose(sclk) |-> !cs_n ##2 !cs_n; endproperty
  a_in_frame: assert property (p_in_frame) else $error("select rose inside a clock");
  property p_hold; sclk |-> $stable(serial_data_in_line); endproperty
  a_hold: assert property (p_hold) else $error("data moved while clock high");
  property p_high; $rose(sclk) |-> sclk [*3] ##1 !sclk; endproperty
  a_high: assert property (p_high) else $error("clock high phase not 3 cycles");
  property p_low; $fell(sclk) |-> !sclk [*4]; endproperty
  a_low: assert property (p_low) else $error("clock low phase too short");
  property p_setup; $fell(cs_n) |-> !sclk [*4]; endproperty
  a_setup: assert property (p_setup) else $error("first clock too early");
  property p_gap; $rose(cs_n) |-> cs_n [*8]; endproperty
  a_gap: assert property (p_gap) else $error("select gap too short");
  property p_len; $rose(cs_n) |-> nclk != 8'h00 && !nclk[0]; endproperty
  a_len: assert property (p_len) else $error("frame not on a byte boundary");
  c_erase: cover property ($rose(cs_n) && nclk == 8'h20);
  c_read: cover property ($rose(cs_n) && nclk == 8'h10);
  c_quad: cover property ($rose(cs_n) && nclk == 8'h02);
  c_reply: cover property (!cs_n && status_out_line);
endmodule

// >>> verification/serial_flash_erase_commands_tb.sv
// Bench for the flash erase link: controller end and flash end joined by one link.
// Assumes software access over AXI4-Lite and erase times shortened to T cycles.
module serial_flash_erase_commands_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int T = 3000;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, stall = 0;
  logic awready, wready, bvalid, arready, rvalid, start_p, done_p, running;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [1:0] bresp, rresp, link_mode = 2'h0;
  logic [flash_erase_pkg::SECTORS-1:0] sector_lock = '0;
  logic [23:0] base;
  flash_erase_pkg::erase_kind_t kind;
  int n_errors = 0, compares = 0, n_start = 0, n_done = 0;
  flash_link_if lk ();
  flash_erase_host i_flash_erase_host (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid,
    .wready, .wdata, .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0),
    .rvalid, .rready, .rdata, .rresp, .link(lk));
  flash_erase_device #(.SUBSECTOR_ERASE_CYCLES(T), .SECTOR_ERASE_CYCLES(T), .DIE_ERASE_CYCLES(T),
    .BULK_ERASE_CYCLES(T)) i_flash_erase_device (.aclk, .aresetn, .link(lk), .link_mode, .sector_lock,
    .erase_stall(stall), .erase_start(start_p), .erase_done(done_p), .erase_kind(kind), .erase_base(base),
    .erase_running(running));
  flash_erase_chk i_flash_erase_chk (.aclk, .aresetn, .cs_n(lk.cs_n), .sclk(lk.sclk),
    .serial_data_in_line(lk.serial_data_in_line), .status_out_line(lk.status_out_line));
  initial forever #5 aclk = ~aclk;
  always @(posedge aclk) begin
    if (start_p === 1'b1) n_start++;
    if (done_p === 1'b1) n_done++;
  end
  ////////////////////////////////////////
  task complete_run();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do @(posedge aclk); while (!awready);
    awvalid <= 1'b0; wvalid <= 1'b0;
    while (!bvalid) @(posedge aclk);
    chk(bresp, (a == flash_erase_pkg::REG_LINK_ADDR || a == flash_erase_pkg::REG_LINK_CMD) ?
        flash_erase_pkg::RESP_OKAY : flash_erase_pkg::RESP_SLVERR);
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    d = rdata; r = rresp; rready <= 1'b0;
    @(posedge aclk);
  endtask
  // One frame; waits until the controller is idle again
  task op(input logic [7:0] c, input logic [1:0] m, input logic ad, input logic rb, input logic [23:0] a,
          output logic [7:0] b);
    logic [31:0] d;
    logic [1:0] r;
    link_mode <= m;
    wr(flash_erase_pkg::REG_LINK_ADDR, {8'h00, a});
    wr(flash_erase_pkg::REG_LINK_CMD, {20'h0_0000, rb, ad, m, c});
    do rd(flash_erase_pkg::REG_LINK_STAT, d, r); while (d[0] !== 1'b0);
    b = d[15:8];
  endtask
  task x(input logic [7:0] c, input logic ad, input logic [23:0] a);
    logic [7:0] b;
    op(c, 2'h0, ad, 1'b0, a, b);
  endtask
  task we();
    x(flash_erase_pkg::CMD_WRITE_ENABLE, 1'b0, 24'h00_0000);
  endtask
  task rdb(input logic [7:0] c, input logic [7:0] e);
    logic [7:0] b;
    op(c, 2'h0, 1'b0, 1'b1, 24'h00_0000, b);
    chk(b, e);
  endtask
  task st(input logic [7:0] e); rdb(flash_erase_pkg::CMD_READ_STATUS, e); endtask
  task fl(input logic [7:0] e); rdb(flash_erase_pkg::CMD_READ_FLAGS, e); endtask
  initial begin
    repeat (60000) @(posedge aclk);
    n_errors++;
    complete_run();
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] b;
    static logic [7:0] c [4] = '{flash_erase_pkg::CMD_SUBSECTOR_ERASE, flash_erase_pkg::CMD_SECTOR_ERASE,
                          flash_erase_pkg::CMD_DIE_ERASE, flash_erase_pkg::CMD_BULK_ERASE};
    static logic [23:0] eb [4] = '{24'h12_3000, 24'h12_0000, 24'h00_0000, 24'h00_0000};
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'hfc, d, r);
    chk({d[29:0], r}, {30'h0000_0000, flash_erase_pkg::RESP_SLVERR});
    wr(8'hfc, 32'h0000_0000);
    x(c[1], 1'b1, 24'h12_0000);
    chk(n_start, 0);
    fl(8'h80);
    we();
    st(8'h02);
    x(flash_erase_pkg::CMD_WRITE_DISABLE, 1'b0, 24'h00_0000);
    st(8'h00);
    for (int m = 1; m < 3; m++) begin
      op(flash_erase_pkg::CMD_WRITE_ENABLE, 2'(m), 1'b0, 1'b0, 24'h00_0000, b);
      st(8'h02);
      x(flash_erase_pkg::CMD_WRITE_DISABLE, 1'b0, 24'h00_0000);
    end
    we();
    x(c[1], 1'b0, 24'h00_0000);
    st(8'h02);
    for (int i = 0; i < 4; i++) begin
      if (i > 0) we();
      x(c[i], i != 3, 24'h12_3456);
      we();
      chk({kind, base, running}, {2'(i), eb[i], 1'b1});
      st(8'h01);
      fl(8'h00);
      if (i == 0) begin
        x(flash_erase_pkg::CMD_SUSPEND, 1'b0, 24'h00_0000);
        fl(8'hc0);
        x(flash_erase_pkg::CMD_RESUME, 1'b0, 24'h00_0000);
        fl(8'h00);
      end
      while (done_p !== 1'b1) @(posedge aclk);
      st(8'h00);
      fl(8'h80);
    end
    chk(n_done, 4);
    sector_lock[8'h12] <= 1'b1;
    we();
    x(c[1], 1'b1, 24'h12_8000);
    fl(8'ha2);
    x(flash_erase_pkg::CMD_WRITE_DISABLE, 1'b0, 24'h00_0000);
    st(8'h02);
    x(c[2], 1'b1, 24'h00_0000);
    fl(8'ha2);
    x(flash_erase_pkg::CMD_CLEAR_FLAGS, 1'b0, 24'h00_0000);
    st(8'h00);
    sector_lock <= '0;
    stall <= 1'b1;
    we();
    x(c[0], 1'b1, 24'h00_0000);
    repeat (2 * T + 200) @(posedge aclk);
    stall <= 1'b0;
    fl(8'ha0);
    st(8'h00);
    complete_run();
  end
endmodule
